// ===== logic/bslse_exec.sv
// Execution unit for skips, flag branches, loads and stores
`default_nettype none
module bslse_exec (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic issue_valid,
    output logic issue_ready,
    input wire bslse_pkg::bslse_issue_s issue,
    input wire logic [7:0] status_register,
    output bslse_pkg::bslse_retire_s retire,
    output bslse_pkg::bslse_rf_s rf_wr,
    output bslse_pkg::bslse_dm_s dm_req,
    input wire logic [7:0] dm_rdata,
    output bslse_pkg::bslse_pm_s pm_req,
    input wire logic [7:0] pm_rdata,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    // ****************************************
    // State and held operands
    // ****************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } bslse_state_e;

    bslse_state_e state;
    bslse_state_e next_state;
    logic [1:0] cnt, next_cnt;
    logic exec_en, last_taken, hold_pgm, hold_load, hold_taken, hold_ptr_we;
    logic [7:0] high_page_selector;
    logic [31:0] retired;
    logic [4:0] hold_rd;
    logic [15:0] hold_pc, hold_ptr_data;
    bslse_pkg::bslse_ptr_e hold_ptr;

    // ****************************************
    // Decode of the issued instruction
    // ****************************************
    logic accept, is_skip, is_branch, is_ind, is_load, is_store, is_pgm;
    logic skip_hit, branch_hit, sign_diff, ptr_we_new, last_cycle;
    logic [1:0] n_cyc;
    logic [15:0] ptr_dec, ptr_inc, ptr_disp, eff_addr, pc_seq, pc_branch;
    logic [15:0] pc_skip, pc_new, ptr_data_new;

    // Only status_register is read; no flag is ever written back
    function automatic logic flag_test(
        input bslse_pkg::bslse_op_e op,
        input logic [2:0] sel,
        input logic [7:0] sr,
        input logic sdiff
    );
        logic hit;
        hit = 1'b0;
        unique case (op)
            bslse_pkg::BRANCH_FLAG_SET: hit = sr[sel];
            bslse_pkg::BRANCH_FLAG_CLEAR: hit = !sr[sel];
            bslse_pkg::BRANCH_EQUAL: hit = sr[bslse_pkg::FLAG_Z];
            bslse_pkg::BRANCH_NOT_EQUAL: hit = !sr[bslse_pkg::FLAG_Z];
            bslse_pkg::BRANCH_CARRY_SET,
            bslse_pkg::BRANCH_UNSIGNED_LOWER:
                hit = sr[bslse_pkg::FLAG_C];
            bslse_pkg::BRANCH_CARRY_CLEAR,
            bslse_pkg::BRANCH_SAME_OR_HIGHER:
                hit = !sr[bslse_pkg::FLAG_C];
            bslse_pkg::BRANCH_MINUS: hit = sr[bslse_pkg::FLAG_N];
            bslse_pkg::BRANCH_PLUS: hit = !sr[bslse_pkg::FLAG_N];
            bslse_pkg::BRANCH_SIGNED_GE: hit = !sdiff;
            bslse_pkg::BRANCH_SIGNED_LT: hit = sdiff;
            bslse_pkg::BRANCH_HALFCARRY_SET:
                hit = sr[bslse_pkg::FLAG_H];
            bslse_pkg::BRANCH_HALFCARRY_CLEAR:
                hit = !sr[bslse_pkg::FLAG_H];
            bslse_pkg::BRANCH_TRANSFER_SET:
                hit = sr[bslse_pkg::FLAG_T];
            bslse_pkg::BRANCH_TRANSFER_CLEAR:
                hit = !sr[bslse_pkg::FLAG_T];
            bslse_pkg::BRANCH_OVERFLOW_SET:
                hit = sr[bslse_pkg::FLAG_V];
            bslse_pkg::BRANCH_OVERFLOW_CLEAR:
                hit = !sr[bslse_pkg::FLAG_V];
            bslse_pkg::BRANCH_IRQ_ENABLED:
                hit = sr[bslse_pkg::FLAG_I];
            bslse_pkg::BRANCH_IRQ_DISABLED:
                hit = !sr[bslse_pkg::FLAG_I];
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    // Handshake and instruction class
    assign issue_ready = (state == ST_IDLE) && exec_en;
    assign accept = issue_valid && issue_ready;
    assign is_skip = (issue.op == bslse_pkg::SKIP_IF_IO_BIT_CLEAR) ||
        (issue.op == bslse_pkg::SKIP_IF_IO_BIT_SET);
    assign is_branch = (issue.op >= bslse_pkg::BRANCH_FLAG_SET) &&
        (issue.op <= bslse_pkg::BRANCH_IRQ_DISABLED);
    assign is_pgm = issue.op == bslse_pkg::EXTENDED_PROGRAM_LOAD;
    assign is_store = issue.op == bslse_pkg::INDIRECT_STORE;
    assign is_load = (issue.op == bslse_pkg::INDIRECT_LOAD) ||
        (issue.op == bslse_pkg::DISPLACED_LOAD) ||
        (issue.op == bslse_pkg::DIRECT_LOAD);
    assign is_ind = (issue.op == bslse_pkg::INDIRECT_LOAD) || is_store;

    // Condition evaluation
    assign skip_hit =
        ((issue.op == bslse_pkg::SKIP_IF_IO_BIT_CLEAR) &&
        !issue.io_value[issue.bit_sel]) ||
        ((issue.op == bslse_pkg::SKIP_IF_IO_BIT_SET) &&
        issue.io_value[issue.bit_sel]);
    assign sign_diff = status_register[bslse_pkg::FLAG_N] ^
        status_register[bslse_pkg::FLAG_V];
    assign branch_hit = is_branch &&
        flag_test(issue.op, issue.flag_sel, status_register, sign_diff);

    // Program counter candidates
    assign pc_seq = issue.pc + 16'h0001;
    assign pc_branch = issue.pc + {{9{issue.offset[6]}}, issue.offset} +
        16'h0001;
    assign pc_skip = issue.pc +
        (issue.next_two_word ? 16'h0003 : 16'h0002);
    assign pc_new = skip_hit ? pc_skip :
        (branch_hit ? pc_branch : pc_seq);

    // Cycle count per class
    assign n_cyc = is_pgm ? bslse_pkg::CYC_PGM_LOAD :
        (is_load || is_store) ? bslse_pkg::CYC_DATA_MEM :
        branch_hit ? bslse_pkg::CYC_BRANCH_TAKEN :
        !skip_hit ? bslse_pkg::CYC_ONE :
        issue.next_two_word ? bslse_pkg::CYC_SKIP_LONG :
        bslse_pkg::CYC_SKIP_SHORT;

    // Pointer arithmetic and effective address
    assign ptr_dec = issue.ptr_value - 16'h0001;
    assign ptr_inc = issue.ptr_value + 16'h0001;
    assign ptr_disp = issue.ptr_value + {10'h000, issue.disp};
    assign eff_addr =
        (issue.op == bslse_pkg::DIRECT_LOAD) ? issue.abs_addr :
        (issue.op == bslse_pkg::DISPLACED_LOAD) ? ptr_disp :
        (issue.mode == bslse_pkg::MODE_PRE_DEC) ? ptr_dec :
        issue.ptr_value;
    assign ptr_we_new = is_ind &&
        (issue.mode != bslse_pkg::MODE_PLAIN);
    assign ptr_data_new = (issue.mode == bslse_pkg::MODE_POST_INC) ?
        ptr_inc : ptr_dec;

    // Sequencing
    assign last_cycle = (state == ST_BUSY) && (cnt == 2'h1);
    assign next_state = (accept && (n_cyc != bslse_pkg::CYC_ONE)) ?
        ST_BUSY : (last_cycle ? ST_IDLE : state);
    assign next_cnt = accept ? n_cyc - 2'h1 :
        ((state == ST_BUSY) ? cnt - 2'h1 : cnt);

    // ****************************************
    // Sequencer registers
    // ****************************************
    // State and remaining cycles
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            cnt <= 2'h0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    // Operands kept for the closing cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hold_pgm <= 1'b0;
            hold_load <= 1'b0;
            hold_taken <= 1'b0;
            hold_rd <= 5'h00;
            hold_pc <= 16'h0000;
            hold_ptr_we <= 1'b0;
            hold_ptr <= bslse_pkg::PTR_X;
            hold_ptr_data <= 16'h0000;
        end else if (accept) begin
            hold_pgm <= is_pgm;
            hold_load <= is_load;
            hold_taken <= skip_hit || branch_hit;
            hold_rd <= issue.rd;
            hold_pc <= pc_new;
            hold_ptr_we <= ptr_we_new;
            hold_ptr <= issue.ptr;
            hold_ptr_data <= ptr_data_new;
        end
    end

    // ****************************************
    // Memory requests
    // ****************************************
    // One-cycle strobes issued on acceptance
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dm_req <= '0;
            pm_req <= '0;
        end else begin
            dm_req.re <= accept && is_load;
            dm_req.we <= accept && is_store;
            pm_req.re <= accept && is_pgm;
            if (accept) begin
                dm_req.addr <= eff_addr;
                dm_req.wdata <= issue.rr_value;
                pm_req.addr <= {high_page_selector[bslse_pkg::HPS_PAGE_BIT],
                    issue.ptr_value};
            end
        end
    end

    // ****************************************
    // Retirement and write-back
    // ****************************************
    // Single-cycle ops retire at acceptance, others at the last cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            retire <= '0;
        end else if (accept && (n_cyc == bslse_pkg::CYC_ONE)) begin
            retire.valid <= 1'b1;
            retire.taken <= 1'b0;
            retire.pc <= pc_new;
        end else begin
            retire.valid <= last_cycle;
            if (last_cycle) begin
                retire.taken <= hold_taken;
                retire.pc <= hold_pc;
            end
        end
    end

    // Destination and pointer written in the closing cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rf_wr <= '0;
        end else begin
            rf_wr.rd_we <= last_cycle && (hold_load || hold_pgm);
            rf_wr.ptr_we <= last_cycle && hold_ptr_we;
            if (last_cycle) begin
                rf_wr.rd_addr <= hold_pgm ? 5'h00 : hold_rd;
                rf_wr.rd_data <= hold_pgm ? pm_rdata : dm_rdata;
                rf_wr.ptr <= hold_ptr;
                rf_wr.ptr_data <= hold_ptr_data;
            end
        end
    end

    // ****************************************
    // APB register file
    // ****************************************
    logic apb_wr, hit_ctrl, hit_hps, hit_stat, hit_ret;
    logic [31:0] rd_mux;

    // Address decode and read selection
    assign apb_wr = psel && penable && pwrite;
    assign hit_ctrl = paddr == bslse_pkg::ADDR_CTRL;
    assign hit_hps = paddr == bslse_pkg::ADDR_HPS;
    assign hit_stat = paddr == bslse_pkg::ADDR_STAT;
    assign hit_ret = paddr == bslse_pkg::ADDR_RETIRED;
    assign rd_mux = hit_ctrl ? {31'h0, exec_en} :
        hit_hps ? {24'h0, high_page_selector} :
        hit_stat ? {30'h0, last_taken, state == ST_BUSY} :
        hit_ret ? retired : 32'h0000_0000;
    assign pready = 1'b1;
    assign pslverr = psel && penable &&
        !(hit_ctrl || hit_hps || hit_stat || hit_ret);

    // Writable controls
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            exec_en <= bslse_pkg::CTRL_EN_RST;
            high_page_selector <= bslse_pkg::HPS_RST;
        end else if (apb_wr) begin
            if (hit_ctrl) exec_en <= pwdata[bslse_pkg::CTRL_EN_BIT];
            if (hit_hps) high_page_selector <= pwdata[7:0];
        end
    end

    // Read data and retirement statistics
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
            retired <= bslse_pkg::RETIRED_RST;
            last_taken <= 1'b0;
        end else begin
            if (psel && !penable && !pwrite) prdata <= rd_mux;
            if (retire.valid) begin
                retired <= retired + 32'h0000_0001;
                last_taken <= retire.taken;
            end
        end
    end
endmodule // bslse_exec
`default_nettype wire

// ===== logic/bslse_pkg.sv
// Constants, types and register map of the branch/skip/load/store unit
`default_nettype none
package bslse_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_HPS = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam logic [7:0] ADDR_RETIRED = 8'h0c;
    localparam int CTRL_EN_BIT = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_TAKEN_BIT = 1;
    localparam int HPS_PAGE_BIT = 0;
    localparam logic CTRL_EN_RST = 1'b1;
    localparam logic [7:0] HPS_RST = 8'h00;
    localparam logic [31:0] RETIRED_RST = 32'h0000_0000;

    // ****************************************
    // Status flag positions
    // ****************************************
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    // ****************************************
    // Cycle counts
    // ****************************************
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_BRANCH_TAKEN = 2'h2;
    localparam logic [1:0] CYC_SKIP_SHORT = 2'h2;
    localparam logic [1:0] CYC_SKIP_LONG = 2'h3;
    localparam logic [1:0] CYC_DATA_MEM = 2'h2;
    localparam logic [1:0] CYC_PGM_LOAD = 2'h3;

    // ****************************************
    // Operations and operand modes
    // ****************************************
    typedef enum logic [4:0] {
        SKIP_IF_IO_BIT_CLEAR, SKIP_IF_IO_BIT_SET,
        BRANCH_FLAG_SET, BRANCH_FLAG_CLEAR,
        BRANCH_EQUAL, BRANCH_NOT_EQUAL,
        BRANCH_CARRY_SET, BRANCH_CARRY_CLEAR,
        BRANCH_SAME_OR_HIGHER, BRANCH_UNSIGNED_LOWER,
        BRANCH_MINUS, BRANCH_PLUS,
        BRANCH_SIGNED_GE, BRANCH_SIGNED_LT,
        BRANCH_HALFCARRY_SET, BRANCH_HALFCARRY_CLEAR,
        BRANCH_TRANSFER_SET, BRANCH_TRANSFER_CLEAR,
        BRANCH_OVERFLOW_SET, BRANCH_OVERFLOW_CLEAR,
        BRANCH_IRQ_ENABLED, BRANCH_IRQ_DISABLED,
        EXTENDED_PROGRAM_LOAD, INDIRECT_LOAD,
        DISPLACED_LOAD, DIRECT_LOAD, INDIRECT_STORE
    } bslse_op_e;

    typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z} bslse_ptr_e;
    typedef enum logic [1:0] {
        MODE_PLAIN, MODE_POST_INC, MODE_PRE_DEC
    } bslse_mode_e;

    // Instruction handed over by decode
    typedef struct packed {
        bslse_op_e op;
        bslse_ptr_e ptr;
        bslse_mode_e mode;
        logic [2:0] flag_sel;
        logic [2:0] bit_sel;
        logic [7:0] io_value;
        logic [6:0] offset;
        logic [5:0] disp;
        logic [15:0] abs_addr;
        logic [4:0] rd;
        logic [7:0] rr_value;
        logic [15:0] ptr_value;
        logic [15:0] pc;
        logic next_two_word;
    } bslse_issue_s;

    // Retirement report
    typedef struct packed {
        logic valid;
        logic taken;
        logic [15:0] pc;
    } bslse_retire_s;

    // Register-file write, destination and pointer
    typedef struct packed {
        logic rd_we;
        logic [4:0] rd_addr;
        logic [7:0] rd_data;
        logic ptr_we;
        bslse_ptr_e ptr;
        logic [15:0] ptr_data;
    } bslse_rf_s;

    // Data memory request
    typedef struct packed {
        logic re;
        logic we;
        logic [15:0] addr;
        logic [7:0] wdata;
    } bslse_dm_s;

    // Program memory request
    typedef struct packed {
        logic re;
        logic [16:0] addr;
    } bslse_pm_s;
endpackage
`default_nettype wire

// ===== dv/bslse_exec_chk.sv
// Assertion checker for the branch/skip/load/store unit
`default_nettype none
module bslse_exec_chk (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic issue_valid,
    input wire logic issue_ready,
    input wire bslse_pkg::bslse_issue_s issue,
    input wire logic [7:0] status_register,
    input wire bslse_pkg::bslse_retire_s retire,
    input wire bslse_pkg::bslse_rf_s rf_wr,
    input wire bslse_pkg::bslse_dm_s dm_req,
    input wire logic [7:0] dm_rdata,
    input wire bslse_pkg::bslse_pm_s pm_req
);
    // ****************************************
    // Accepted issues by kind
    // ****************************************
    // Decode of the accepting edge
    wire logic acc = issue_valid && issue_ready;
    wire logic pgm = acc && issue.op == bslse_pkg::EXTENDED_PROGRAM_LOAD;
    wire logic dload = acc && issue.op == bslse_pkg::DIRECT_LOAD;
    wire logic pre_load = acc && issue.op == bslse_pkg::INDIRECT_LOAD &&
        issue.mode == bslse_pkg::MODE_PRE_DEC;
    wire logic store_acc = acc && issue.op == bslse_pkg::INDIRECT_STORE;
    wire logic eq_op = acc && issue.op == bslse_pkg::BRANCH_EQUAL;
    wire logic skip_long = acc && issue.op == bslse_pkg::SKIP_IF_IO_BIT_SET &&
        issue.io_value[issue.bit_sel] && issue.next_two_word;
    wire logic [15:0] k_ext = {{9{issue.offset[6]}}, issue.offset};

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    // One quiet cycle, then the retirement
    sequence gap_then_retire;
        !retire.valid ##1 retire.valid;
    endsequence

    // ****************************************
    // Properties
    // ****************************************
    pgm_addr_a: assert property (
        pgm |=> pm_req.re && pm_req.addr[15:0] == $past(issue.ptr_value))
        else $error("pm addr");
    pgm_retire_a: assert property (
        pgm |=> !retire.valid ##1 gap_then_retire ##0 rf_wr.rd_we &&
        rf_wr.rd_addr == 5'h00)
        else $error("pm retire");
    direct_addr_a: assert property (
        dload |=> dm_req.re && dm_req.addr == $past(issue.abs_addr)
        ##1 retire.valid && rf_wr.rd_we)
        else $error("direct load");
    busy_refuse_a: assert property (
        dload |=> !issue_ready)
        else $error("busy accept");
    load_data_a: assert property (
        dm_req.re && !dm_req.we |=> rf_wr.rd_we &&
        rf_wr.rd_data == $past(dm_rdata))
        else $error("load data");
    pre_dec_a: assert property (
        pre_load |=> dm_req.addr == $past(issue.ptr_value) - 16'h0001 ##1
        rf_wr.ptr_we && rf_wr.ptr_data == $past(issue.ptr_value, 2) - 16'h0001)
        else $error("pre-dec load");
    store_data_a: assert property (
        store_acc |=> dm_req.we && !dm_req.re &&
        dm_req.wdata == $past(issue.rr_value))
        else $error("store data");
    br_taken_a: assert property (
        eq_op && status_register[1] |=> gap_then_retire ##0 retire.taken &&
        retire.pc == $past(issue.pc, 2) + $past(k_ext, 2) + 16'h0001)
        else $error("taken branch");
    br_untaken_a: assert property (
        eq_op && !status_register[1] |=> retire.valid && !retire.taken &&
        retire.pc == $past(issue.pc) + 16'h0001)
        else $error("untaken branch");
    skip_long_a: assert property (
        skip_long |=> !retire.valid [*2] ##1 retire.valid &&
        retire.pc == $past(issue.pc, 3) + 16'h0003)
        else $error("long skip");
endmodule // bslse_exec_chk

bind bslse_exec bslse_exec_chk bslse_exec_chk_inst (.clock, .rst_n,
    .issue_valid, .issue_ready, .issue, .status_register, .retire, .rf_wr,
    .dm_req, .dm_rdata, .pm_req);
`default_nettype wire

// ===== dv/bslse_mem.sv
// Data and program memory model
`default_nettype none
module bslse_mem (
    input wire logic clock,
    input wire bslse_pkg::bslse_dm_s dm_req,
    output logic [7:0] dm_rdata,
    input wire bslse_pkg::bslse_pm_s pm_req,
    output logic [7:0] pm_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [256];
    logic [7:0] last;
    // Data only while a read is asked, else a pattern that keeps changing
    assign dm_rdata = dm_req.re ? mem[dm_req.addr[7:0]] : ~last;
    // Known contents: each byte is its address xor 5a
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'h5a;
        end
        last = 8'h00;
        pm_rdata = 8'h00;
    end
    // Writes, read history and a held program byte
    always @(posedge clock) begin
        if (dm_req.we) begin
            mem[dm_req.addr[7:0]] <= dm_req.wdata;
        end
        last <= dm_rdata;
        if (pm_req.re) begin
            pm_rdata <= pm_req.addr[7:0] ^ pm_req.addr[15:8] ^
                {pm_req.addr[16], 7'h00};
        end
    end
endmodule // bslse_mem
`default_nettype wire

// ===== dv/branch_skip_load_store_exec_tb.sv
// Self-checking bench for the branch/skip/load/store unit
`default_nettype none
module branch_skip_load_store_exec_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [2:0] sel;
        logic [7:0] val;
        logic [1:0] tt;
    } bslse_row_s;
    logic clock, rst_n, issue_valid, issue_ready, psel, penable, pwrite;
    logic pready, pslverr, err, t;
    logic [7:0] status_register, paddr, dm_rdata, pm_rdata, v, next_sr;
    logic [31:0] pwdata, prdata, rdat;
    logic [15:0] exp_pc;
    bslse_pkg::bslse_issue_s issue, next_issue;
    bslse_pkg::bslse_retire_s retire;
    bslse_pkg::bslse_rf_s rf_wr;
    bslse_pkg::bslse_dm_s dm_req;
    bslse_pkg::bslse_pm_s pm_req;
    int n_errors, check_count, cycles, exp_n;
    int n_ret = 0;
    int tmo = 0;
    // Row index is the op code: select, flags or I/O byte, {long, taken}
    bslse_row_s rows [22] = '{'{3'h3, 8'hf7, 2'h1},
        '{3'h7, 8'h80, 2'h3}, '{3'h4, 8'h10, 2'h1},
        '{3'h2, 8'hfb, 2'h1}, '{3'h0, 8'h02, 2'h1},
        '{3'h0, 8'h02, 2'h0}, '{3'h0, 8'h01, 2'h1},
        '{3'h0, 8'h01, 2'h0}, '{3'h0, 8'h01, 2'h0},
        '{3'h0, 8'h01, 2'h1}, '{3'h0, 8'h04, 2'h1},
        '{3'h0, 8'h04, 2'h0}, '{3'h0, 8'h0c, 2'h1},
        '{3'h0, 8'h08, 2'h1}, '{3'h0, 8'h20, 2'h1},
        '{3'h0, 8'h20, 2'h0}, '{3'h0, 8'h40, 2'h1},
        '{3'h0, 8'h40, 2'h0}, '{3'h0, 8'h08, 2'h1},
        '{3'h0, 8'h08, 2'h0}, '{3'h0, 8'h80, 2'h1},
        '{3'h0, 8'h80, 2'h0}};

    // ****************************************
    // Design, memory and clock
    // ****************************************
    bslse_exec bslse_exec_inst (.clock, .rst_n, .issue_valid, .issue_ready,
        .issue, .status_register, .retire, .rf_wr, .dm_req, .dm_rdata,
        .pm_req, .pm_rdata, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr);
    bslse_mem bslse_mem_inst (.clock, .dm_req, .dm_rdata, .pm_req,
        .pm_rdata);
    // Free-running core clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Retirement count and hang guard
    always @(posedge clock) begin
        tmo <= tmo + 1;
        if (retire.valid === 1'b1) n_ret <= n_ret + 1;
        if (tmo == 5000) begin
            n_errors++;
            final_report();
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] exp,
            input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
            input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Offer one instruction, count cycles from acceptance to retirement
    task automatic exec(input bslse_pkg::bslse_op_e op);
        @(posedge clock);
        next_issue.op = op;
        issue <= next_issue;
        status_register <= next_sr;
        issue_valid <= 1'b1;
        do @(negedge clock); while (issue_ready !== 1'b1);
        @(posedge clock);
        issue_valid <= 1'b0;
        cycles = 0;
        do begin
            @(negedge clock);
            cycles++;
        end while (retire.valid !== 1'b1 && cycles < 8);
    endtask
    task automatic mem_run(input bslse_pkg::bslse_op_e op,
            input bslse_pkg::bslse_ptr_e ptr,
            input bslse_pkg::bslse_mode_e mode, input logic [15:0] pv,
            input logic upd, input logic [15:0] ptr_exp = 16'h0000);
        next_issue.ptr = ptr;
        next_issue.mode = mode;
        next_issue.ptr_value = pv;
        exec(op);
        check("memory cycles", 32'd2, cycles);
        check("pointer write", {31'h0, upd}, {31'h0, rf_wr.ptr_we});
        if (upd) check("pointer", {16'h0, ptr_exp}, {16'h0, rf_wr.ptr_data});
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst_n = 1'b0;
        issue_valid = 1'b0;
        issue = '0;
        next_issue = '0;
        next_sr = 8'h00;
        status_register = 8'h00;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        n_errors = 0;
        check_count = 0;
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        @(negedge clock);
        check("ready after reset", 32'h1, {31'h0, issue_ready});
        apb(1'b0, bslse_pkg::ADDR_CTRL, 32'h0);
        check("control reset", 32'h1, rdat);
        apb(1'b0, bslse_pkg::ADDR_HPS, 32'h0);
        check("page reset", 32'h0, rdat);
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped error", 32'h1, {31'h0, err});
        $display("test reset done");
        next_issue.pc = 16'h0100;
        next_issue.offset = 7'h40;
        for (int i = 0; i < 22; i++) begin
            for (int p = 0; p < 2; p++) begin
                v = rows[i].val ^ ((p == 0) ? 8'h00 :
                    (i == 12 || i == 13) ? 8'hfb : 8'hff);
                t = rows[i].tt[0] ^ p[0];
                next_issue.flag_sel = rows[i].sel;
                next_issue.bit_sel = rows[i].sel;
                next_issue.io_value = v;
                next_issue.next_two_word = rows[i].tt[1];
                next_sr = v;
                exp_n = !t ? 1 : (i > 1 || !rows[i].tt[1]) ? 2 : 3;
                exp_pc = !t ? 16'h0101 : (i > 1) ? 16'h00c1 :
                    16'h0100 + 16'(exp_n);
                exec(bslse_pkg::bslse_op_e'(i));
                check("cycles", exp_n, cycles);
                check("next pc", {16'h0, exp_pc}, {16'h0, retire.pc});
            end
        end
        $display("test branches and skips done");
        next_issue.rd = 5'h11;
        mem_run(bslse_pkg::INDIRECT_LOAD, bslse_pkg::PTR_Z,
            bslse_pkg::MODE_PRE_DEC, 16'h0000, 1'b1, 16'hffff);
        check("load data", 32'ha5, {24'h0, rf_wr.rd_data});
        check("load dest", 32'h11, {27'h0, rf_wr.rd_addr});
        mem_run(bslse_pkg::INDIRECT_LOAD, bslse_pkg::PTR_Y,
            bslse_pkg::MODE_POST_INC, 16'hffff, 1'b1, 16'h0000);
        check("post-inc data", 32'ha5, {24'h0, rf_wr.rd_data});
        next_issue.disp = 6'h3f;
        mem_run(bslse_pkg::DISPLACED_LOAD, bslse_pkg::PTR_Z,
            bslse_pkg::MODE_PLAIN, 16'h0020, 1'b0);
        check("displaced data", 32'h05, {24'h0, rf_wr.rd_data});
        next_issue.abs_addr = 16'h0077;
        mem_run(bslse_pkg::DIRECT_LOAD, bslse_pkg::PTR_X,
            bslse_pkg::MODE_PLAIN, 16'h0000, 1'b0);
        check("direct data", 32'h2d, {24'h0, rf_wr.rd_data});
        next_issue.rr_value = 8'hc3;
        mem_run(bslse_pkg::INDIRECT_STORE, bslse_pkg::PTR_X,
            bslse_pkg::MODE_POST_INC, 16'h0030, 1'b1, 16'h0031);
        next_issue.rr_value = 8'h3c;
        mem_run(bslse_pkg::INDIRECT_STORE, bslse_pkg::PTR_Y,
            bslse_pkg::MODE_PRE_DEC, 16'h0040, 1'b1, 16'h003f);
        mem_run(bslse_pkg::INDIRECT_LOAD, bslse_pkg::PTR_X,
            bslse_pkg::MODE_PLAIN, 16'h0030, 1'b0);
        check("stored byte", 32'hc3, {24'h0, rf_wr.rd_data});
        mem_run(bslse_pkg::INDIRECT_LOAD, bslse_pkg::PTR_Y,
            bslse_pkg::MODE_PLAIN, 16'h003f, 1'b0);
        check("pre-dec store", 32'h3c, {24'h0, rf_wr.rd_data});
        $display("test loads and stores done");
        apb(1'b1, bslse_pkg::ADDR_HPS, 32'h0000_0001);
        next_issue.ptr_value = 16'h1234;
        exec(bslse_pkg::EXTENDED_PROGRAM_LOAD);
        check("program cycles", 32'd3, cycles);
        check("program dest", 32'h0, {27'h0, rf_wr.rd_addr});
        check("program byte", 32'ha6, {24'h0, rf_wr.rd_data});
        $display("test program load done");
        apb(1'b1, bslse_pkg::ADDR_CTRL, 32'h0);
        @(posedge clock);
        issue_valid <= 1'b1;
        repeat (4) @(negedge clock);
        check("disabled ready", 32'h0, {31'h0, issue_ready});
        @(posedge clock);
        issue_valid <= 1'b0;
        apb(1'b1, bslse_pkg::ADDR_CTRL, 32'h1);
        apb(1'b0, bslse_pkg::ADDR_RETIRED, 32'h0);
        check("retired count", n_ret, rdat);
        $display("test enable gate done");
        final_report();
    end
endmodule // branch_skip_load_store_exec_tb
`default_nettype wire
